// ==== rca_consts.svh ====
`ifndef RCA_CONSTS_SVH
`define RCA_CONSTS_SVH

// ----------------------------------------------------------------------------
// converter figures
// ----------------------------------------------------------------------------
`define RCA_CNT_W          12              // result width, full scale 4095
`define RCA_FULL_SCALE     12'hfff         // full-scale count
`define RCA_REF_NOMINAL    12'hce6         // expected reference count, ideal ramp
`define RCA_NUM_CHAN       4               // multiplexed user channels
`define RCA_SEL_W          3               // mux select width, user + reference

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RCA_CLK_PERIOD_NS  20              // 50 mhz system clock
`define RCA_CAL_PERIOD_NS  7500000         // 7.5 ms calibration repeat
`define RCA_CAL_CYCLES     (`RCA_CAL_PERIOD_NS / `RCA_CLK_PERIOD_NS)

`endif

// ==== rca_pkg.sv ====
package rca_pkg;

  // ----------------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RCA_WAIT_START = 2'b00,   // waiting for a rising ramp
    RCA_RAMPING    = 2'b01,   // ramp rising, counters live
    RCA_STORE      = 2'b10    // ramp ended, file the result
  } rca_state_e;

  // calibration step, one per conversion
  typedef enum logic [1:0] {
    RCA_CAL_IDLE  = 2'b00,    // no calibration in progress
    RCA_CAL_REF   = 2'b01,    // this ramp measures the reference
    RCA_CAL_THERM = 2'b10,    // this ramp keeps the temperature
    RCA_CAL_APPLY = 2'b11     // this ramp adopts the new slope
  } rca_cal_e;

endpackage

// ==== rca_cnt_if.sv ====
`timescale 1ns/1ps
`include "rca_consts.svh"

// carrier between the sequencer and one capture counter
interface rca_cnt_if #(
  parameter int W = `RCA_CNT_W
);
  logic         start;     // ramp-start pulse, clears and runs
  logic         stop_lvl;  // comparator level, rising edge stops
  logic [W-1:0] count;     // running or held count
  logic         captured;  // a transition stopped the count
  logic         running;   // counter advancing

  modport ctl  (output start, output stop_lvl, input count, input captured, input running);
  modport unit (input start, input stop_lvl, output count, output captured, output running);
endinterface

// ==== rca_ramp_counter.sv ====
`timescale 1ns/1ps
`include "rca_consts.svh"

// ----------------------------------------------------------------------------
// one capture counter: start on ramp start, hold on comparator edge
// ----------------------------------------------------------------------------
module rca_ramp_counter #(
  parameter int W = `RCA_CNT_W
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  sys_rst,
  // sequencer side
  rca_cnt_if.unit    cif
);

  logic [W-1:0] cnt_reg,  cnt_next;    // elapsed clocks since ramp start
  logic         run_reg,  run_next;    // counting
  logic         cap_reg,  cap_next;    // held by a comparator edge
  logic         stp_reg,  stp_next;    // last comparator level, edge detect

  // next state
  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    cap_next = cap_reg;
    stp_next = cif.stop_lvl;
    if (cif.start) begin
      cnt_next = '0;
      run_next = 1'b1;
      cap_next = 1'b0;
    end else if (run_reg) begin
      if (cif.stop_lvl && !stp_reg) begin
        run_next = 1'b0;
        cap_next = 1'b1;
      end else if (cnt_reg != {W{1'b1}}) begin
        // saturate rather than wrap, a wrapped count would look valid
        cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      cap_reg <= 1'b0;
      stp_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      cap_reg <= cap_next;
      stp_reg <= stp_next;
    end
  end

  assign cif.count    = cnt_reg;
  assign cif.captured = cap_reg;
  assign cif.running  = run_reg;

endmodule

// ==== rca_ramp_adc.sv ====
`timescale 1ns/1ps
`include "rca_consts.svh"

// Overview of operation
// - counter starts on ramp-start pulse
// - counter holds on comparator transition
// - result is twelve bits, 4095 full scale
// - ramp end raises interrupt pulse
// - count stored for later reads
// - optional averaging and out-of-range flag
// - channels converted in turn through mux
// - calibration spread over three conversions
// - reference calibration repeats every 7.5 ms
// - one step keeps thermistor temperature
// - two spare capture channels
// - after storing, step mux to next
// - reference count sets ramp slope
module rca_ramp_adc #(
  parameter int NCH        = `RCA_NUM_CHAN,
  parameter int SW         = `RCA_SEL_W,
  parameter int CAL_CYCLES = `RCA_CAL_CYCLES,
  parameter int W          = `RCA_CNT_W
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // ramp generator and comparators
  input  wire logic                 ramp_start_input,
  input  wire logic                 ramp_end_input,
  input  wire logic                 capture_stop_input,
  input  wire logic                 thermistor_capture_input,
  output logic [SW-1:0]             mux_sel,
  // spare capture channels
  input  wire logic [1:0]           aux_start_input,
  input  wire logic [1:0]           aux_stop_input,
  output logic [1:0][W-1:0]         aux_count,
  output logic [1:0]                aux_valid,
  // processor side
  input  wire logic                 avg_enable,
  input  wire logic [SW-1:0]        rd_chan,
  output logic                      eor_irq,
  output logic [W-1:0]              rd_result,
  output logic [W-1:0]              rd_average,
  output logic [W-1:0]              rd_scaled,
  output logic                      rd_out_of_range,
  output logic [W-1:0]              temp_count,
  output logic [W-1:0]              ref_count,
  output logic                      cal_busy
);

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  localparam logic [SW-1:0] REF_SEL = SW'(NCH);   // reference sits above users
  localparam logic [W-1:0]  FULL    = `RCA_FULL_SCALE;
  localparam logic [W-1:0]  NOMINAL = `RCA_REF_NOMINAL;

  // correct a raw count by the measured ramp slope
  function automatic logic [W-1:0] scale_count(input logic [W-1:0] raw,
                                               input logic [W-1:0] refc);
    logic [2*W-1:0] prod;
    logic [2*W-1:0] quo;
    prod = raw * NOMINAL;
    quo  = '0;
    if (refc == '0) begin
      scale_count = raw;                 // no slope yet, pass through
    end else begin
      quo = prod / {{W{1'b0}}, refc};
      scale_count = (quo > {{W{1'b0}}, FULL}) ? FULL : quo[W-1:0];
    end
  endfunction

  // next user channel, wrapping
  function automatic logic [SW-1:0] next_chan(input logic [SW-1:0] c);
    next_chan = (c == SW'(NCH - 1)) ? '0 : c + {{(SW-1){1'b0}}, 1'b1};
  endfunction

  // ----------------------------------------------------------------------------
  // capture counters: 0 main, 1 thermistor, 2..3 spare
  // ----------------------------------------------------------------------------
  rca_cnt_if #(.W(W)) cnt_if [4] ();

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cnt
      rca_ramp_counter #(.W(W)) u_cnt (
        .clk     (clk),
        .sys_rst (sys_rst),
        .cif     (cnt_if[gi])
      );
    end
  endgenerate

  // main and thermistor share the ramp start
  assign cnt_if[0].start    = ramp_start_input;
  assign cnt_if[0].stop_lvl = capture_stop_input;
  assign cnt_if[1].start    = ramp_start_input;
  assign cnt_if[1].stop_lvl = thermistor_capture_input;
  assign cnt_if[2].start    = aux_start_input[0];
  assign cnt_if[2].stop_lvl = aux_stop_input[0];
  assign cnt_if[3].start    = aux_start_input[1];
  assign cnt_if[3].stop_lvl = aux_stop_input[1];

  // spare channels read straight from their counters' flops
  assign aux_count[0] = cnt_if[2].count;
  assign aux_count[1] = cnt_if[3].count;
  assign aux_valid[0] = cnt_if[2].captured;
  assign aux_valid[1] = cnt_if[3].captured;

  // ----------------------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------------------
  rca_pkg::rca_state_e state_reg, state_next;   // ramp phase
  rca_pkg::rca_cal_e   cal_reg,   cal_next;     // calibration step
  logic [SW-1:0]       chan_reg,  chan_next;    // current user channel
  logic                irq_reg,   irq_next;     // end-of-ramp pulse
  logic [31:0]         tmr_reg,   tmr_next;     // calibration interval
  logic                pend_reg,  pend_next;    // calibration due
  logic [W-1:0]        refm_reg,  refm_next;    // latest reference count
  logic [W-1:0]        slope_reg, slope_next;   // reference in use
  logic [W-1:0]        temp_reg,  temp_next;    // thermistor count

  // per-channel storage
  logic [W-1:0]        res_reg  [NCH];          // last raw result
  logic [W-1:0]        res_next [NCH];
  logic [W-1:0]        avg_reg  [NCH];          // running average
  logic [W-1:0]        avg_next [NCH];
  logic [NCH-1:0]      oor_reg,  oor_next;      // out-of-range flags

  // read port
  logic [W-1:0]        rres_reg, rres_next;
  logic [W-1:0]        ravg_reg, ravg_next;
  logic [W-1:0]        rscl_reg, rscl_next;
  logic                roor_reg, roor_next;

  logic                expire;                  // interval elapsed this cycle
  logic                bad;                     // reading unusable
  logic [W:0]          sum;                     // averaging sum, one extra bit

  // mux follows the reference while that step runs
  assign mux_sel = (cal_reg == rca_pkg::RCA_CAL_REF) ? REF_SEL : chan_reg;

  // ----------------------------------------------------------------------------
  // calibration interval and ramp sequencing
  // ----------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cal_next   = cal_reg;
    chan_next  = chan_reg;
    irq_next   = 1'b0;
    refm_next  = refm_reg;
    slope_next = slope_reg;
    temp_next  = temp_reg;
    oor_next   = oor_reg;
    res_next   = res_reg;
    avg_next   = avg_reg;
    // free-running interval timer, reload on expiry
    expire     = (tmr_reg == 32'h0);
    tmr_next   = expire ? 32'(CAL_CYCLES - 1) : tmr_reg - 32'h1;
    pend_next  = pend_reg | expire;
    // no transition or a saturated count cannot be trusted
    bad        = !cnt_if[0].captured || (cnt_if[0].count >= FULL);
    sum        = {1'b0, avg_reg[chan_reg[$clog2(NCH)-1:0]]}
               + {1'b0, cnt_if[0].count};

    unique case (state_reg)
      rca_pkg::RCA_WAIT_START: begin
        // ramp source only pulses after the turn has settled
        if (ramp_start_input) begin
          state_next = rca_pkg::RCA_RAMPING;
        end
      end
      rca_pkg::RCA_RAMPING: begin
        if (ramp_end_input) begin
          irq_next   = 1'b1;
          state_next = rca_pkg::RCA_STORE;
        end
      end
      rca_pkg::RCA_STORE: begin
        state_next = rca_pkg::RCA_WAIT_START;
        if (cal_reg == rca_pkg::RCA_CAL_REF) begin
          // reference ramp: slope measurement, no user channel
          if (!bad) begin
            refm_next = cnt_if[0].count;
          end
          cal_next = rca_pkg::RCA_CAL_THERM;
        end else begin
          // user channel result
          if (bad) begin
            oor_next[chan_reg[$clog2(NCH)-1:0]] = 1'b1;
          end else begin
            oor_next[chan_reg[$clog2(NCH)-1:0]] = 1'b0;
            res_next[chan_reg[$clog2(NCH)-1:0]] = cnt_if[0].count;
            avg_next[chan_reg[$clog2(NCH)-1:0]] = avg_enable ?
                sum[W:1] : cnt_if[0].count;
          end
          chan_next = next_chan(chan_reg);
          unique case (cal_reg)
            rca_pkg::RCA_CAL_THERM: begin
              if (cnt_if[1].captured) begin
                temp_next = cnt_if[1].count;
              end
              cal_next = rca_pkg::RCA_CAL_APPLY;
            end
            rca_pkg::RCA_CAL_APPLY: begin
              slope_next = refm_reg;
              cal_next   = rca_pkg::RCA_CAL_IDLE;
            end
            default: begin
              // idle: open a calibration when one is due
              if (pend_reg) begin
                cal_next  = rca_pkg::RCA_CAL_REF;
                pend_next = expire;       // a fresh expiry is kept
              end
            end
          endcase
        end
      end
      default: begin
        state_next = rca_pkg::RCA_WAIT_START;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // read port, registered one cycle behind rd_chan
  // ----------------------------------------------------------------------------
  always_comb begin
    rres_next = '0;
    ravg_next = '0;
    rscl_next = '0;
    roor_next = 1'b0;
    // unmapped channel numbers read zero
    if (rd_chan < SW'(NCH)) begin
      rres_next = res_reg[rd_chan[$clog2(NCH)-1:0]];
      ravg_next = avg_reg[rd_chan[$clog2(NCH)-1:0]];
      rscl_next = scale_count(res_reg[rd_chan[$clog2(NCH)-1:0]], slope_reg);
      roor_next = oor_reg[rd_chan[$clog2(NCH)-1:0]];
    end
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= rca_pkg::RCA_WAIT_START;
      cal_reg   <= rca_pkg::RCA_CAL_IDLE;
      chan_reg  <= '0;
      irq_reg   <= 1'b0;
      tmr_reg   <= 32'h0;   // first calibration is due at once
      pend_reg  <= 1'b0;
      refm_reg  <= '0;
      slope_reg <= '0;
      temp_reg  <= '0;
      oor_reg   <= '1;      // nothing measured yet
      for (int i = 0; i < NCH; i++) begin
        res_reg[i] <= '0;
        avg_reg[i] <= '0;
      end
      rres_reg  <= '0;
      ravg_reg  <= '0;
      rscl_reg  <= '0;
      roor_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cal_reg   <= cal_next;
      chan_reg  <= chan_next;
      irq_reg   <= irq_next;
      tmr_reg   <= tmr_next;
      pend_reg  <= pend_next;
      refm_reg  <= refm_next;
      slope_reg <= slope_next;
      temp_reg  <= temp_next;
      oor_reg   <= oor_next;
      res_reg   <= res_next;
      avg_reg   <= avg_next;
      rres_reg  <= rres_next;
      ravg_reg  <= ravg_next;
      rscl_reg  <= rscl_next;
      roor_reg  <= roor_next;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign eor_irq         = irq_reg;
  assign rd_result       = rres_reg;
  assign rd_average      = ravg_reg;
  assign rd_scaled       = rscl_reg;
  assign rd_out_of_range = roor_reg;
  assign temp_count      = temp_reg;
  assign ref_count       = slope_reg;
  assign cal_busy        = (cal_reg != rca_pkg::RCA_CAL_IDLE);

endmodule

// ==== rca_ramp_adc_properties.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// port checks for the ramp converter
// ----------------------------------------
module rca_ramp_adc_chk #(
  parameter int NCH        = 4,
  parameter int SW         = 3,
  parameter int CAL_CYCLES = 200,
  parameter int W          = 12
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // ramp and comparators
  input wire logic              ramp_start_input,
  input wire logic              ramp_end_input,
  input wire logic              capture_stop_input,
  input wire logic              thermistor_capture_input,
  input wire logic [SW-1:0]     mux_sel,
  // spare capture channels
  input wire logic [1:0]        aux_start_input,
  input wire logic [1:0]        aux_stop_input,
  input wire logic [1:0][W-1:0] aux_count,
  input wire logic [1:0]        aux_valid,
  // processor side
  input wire logic              avg_enable,
  input wire logic [SW-1:0]     rd_chan,
  input wire logic              eor_irq,
  input wire logic [W-1:0]      rd_result,
  input wire logic [W-1:0]      rd_average,
  input wire logic [W-1:0]      rd_scaled,
  input wire logic              rd_out_of_range,
  input wire logic [W-1:0]      temp_count,
  input wire logic [W-1:0]      ref_count,
  input wire logic              cal_busy
);
  // single domain, so one clock and one disable serve every check
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_irq_cause: assert property (eor_irq |-> $past(ramp_end_input))
    else $error("eor_irq without a ramp end");
  chk_irq_pulse: assert property (eor_irq |=> !eor_irq)
    else $error("eor_irq longer than one cycle");
  // mux may only move while a result is filed, two cycles after the ramp end
  chk_mux_step: assert property ($changed(mux_sel) |-> $past(ramp_end_input, 2))
    else $error("mux_sel moved outside a store");
  chk_ref_busy: assert property (mux_sel < 3'h4 || (mux_sel == 3'h4 && cal_busy))
    else $error("mux code out of range or reference with no calibration step");
  chk_full_scale: assert property (!rd_out_of_range |-> rd_result != 12'hfff)
    else $error("full-scale count reported as valid");
  // with no slope yet the scaled read must equal the raw one
  chk_raw_scale: assert property (ref_count == 12'h000 && $past(ref_count) == 12'h000
    |-> rd_scaled == rd_result) else $error("scaled read differs with no reference");
  chk_store_time: assert property ($changed(temp_count) || $changed(ref_count)
    |-> $past(eor_irq)) else $error("stored count changed outside a store");
  chk_read_zero: assert property (rd_chan >= 3'h4 |=> rd_result == 12'h000
    && rd_average == 12'h000 && !rd_out_of_range) else $error("spare read not zero");
  chk_aux_hold: assert property (aux_valid[0] && !aux_start_input[0]
    |=> $stable(aux_count[0])) else $error("held spare count moved");
  chk_aux_clear: assert property (aux_start_input[1]
    |=> aux_count[1] == 12'h000 && !aux_valid[1]) else $error("spare count not cleared");
endmodule

bind rca_ramp_adc rca_ramp_adc_chk #(.NCH(NCH), .SW(SW), .CAL_CYCLES(CAL_CYCLES), .W(W))
  rca_ramp_adc_chk_inst (
  .clk(clk), .sys_rst(sys_rst), .ramp_start_input(ramp_start_input),
  .ramp_end_input(ramp_end_input), .capture_stop_input(capture_stop_input),
  .thermistor_capture_input(thermistor_capture_input), .mux_sel(mux_sel),
  .aux_start_input(aux_start_input), .aux_stop_input(aux_stop_input),
  .aux_count(aux_count), .aux_valid(aux_valid), .avg_enable(avg_enable),
  .rd_chan(rd_chan), .eor_irq(eor_irq), .rd_result(rd_result), .rd_average(rd_average),
  .rd_scaled(rd_scaled), .rd_out_of_range(rd_out_of_range), .temp_count(temp_count),
  .ref_count(ref_count), .cal_busy(cal_busy)
);

// ==== rca_ramp_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// ramp source, comparators and channel mux
// ----------------------------------------
module rca_ramp_model (
  // clock
  input wire logic       clk,
  // channel select from the converter
  input wire logic [2:0] mux_sel,
  // ramp and comparator lines
  output logic           ramp_start_input,
  output logic           ramp_end_input,
  output logic           capture_stop_input,
  output logic           thermistor_capture_input
);
  logic [15:0] trip [0:4];  // crossing cycle per mux code, ffff never crosses
  logic [15:0] th_trip;     // thermistor crossing cycle

  // quiet lines and a default crossing table
  initial begin
    ramp_start_input         = 1'b0;
    ramp_end_input           = 1'b0;
    capture_stop_input       = 1'b0;
    thermistor_capture_input = 1'b0;
    trip = '{16'd100, 16'd500, 16'hffff, 16'd250, 16'd330};
    th_trip = 16'd77;
  end

  // one sawtooth, far shorter than the real period to keep runs brief
  task automatic ramp(input int len);
    logic [2:0] sel;
    repeat (8) @(posedge clk);     // turn-around settles before the start pulse
    #2 sel = mux_sel;              // mux picks the comparator for the stop line
    ramp_start_input = 1'b1;
    @(posedge clk);
    #2 ramp_start_input = 1'b0;
    for (int i = 1; i <= len; i++) begin
      capture_stop_input = (i > trip[sel]);     // flips once the ramp passes the input
      thermistor_capture_input = (i > th_trip);
      @(posedge clk);
      #2;
    end
    ramp_end_input = 1'b1;
    @(posedge clk);
    #2 ramp_end_input = 1'b0;
    capture_stop_input = 1'b0;     // ramp falls back below every input
    thermistor_capture_input = 1'b0;
  endtask

  // ramp end with no ramp running, a misordered drive the bench asks for
  task automatic end_only();
    ramp_end_input = 1'b1;
    @(posedge clk);
    #2 ramp_end_input = 1'b0;
  endtask
endmodule

// ==== rca_tb.sv ====
`timescale 1ns/1ps
`include "rca_consts.svh"

// ----------------------------------------
// bench for the ramp converter
// ----------------------------------------
module tb;
  localparam int CAL = 16000;      // short calibration repeat keeps the run brief
  logic             clk = 1'b0;    // 50 mhz system clock
  logic             sys_rst = 1'b1;
  logic             ramp_start_input, ramp_end_input, capture_stop_input;
  logic             thermistor_capture_input, eor_irq, rd_out_of_range, cal_busy;
  logic             avg_enable = 1'b0;
  logic [2:0]       mux_sel;
  logic [2:0]       rd_chan = 3'h0;
  logic [1:0]       aux_start_input = 2'b00;
  logic [1:0]       aux_stop_input = 2'b00;
  logic [1:0]       aux_valid;
  logic [1:0][11:0] aux_count;
  logic [11:0]      rd_result, rd_average, rd_scaled, temp_count, ref_count;
  int               n_mismatch = 0;
  int               compares = 0;
  int               cyc = 0;       // cycles since reset release

  always #10 clk = ~clk;
  // cycle count, restarted by reset, times the calibration repeat
  always @(posedge clk) cyc <= sys_rst ? 0 : cyc + 1;

  rca_ramp_adc #(.CAL_CYCLES(CAL)) rca_ramp_adc_inst (
    .clk(clk), .sys_rst(sys_rst), .ramp_start_input(ramp_start_input),
    .ramp_end_input(ramp_end_input), .capture_stop_input(capture_stop_input),
    .thermistor_capture_input(thermistor_capture_input), .mux_sel(mux_sel),
    .aux_start_input(aux_start_input), .aux_stop_input(aux_stop_input),
    .aux_count(aux_count), .aux_valid(aux_valid), .avg_enable(avg_enable),
    .rd_chan(rd_chan), .eor_irq(eor_irq), .rd_result(rd_result), .rd_average(rd_average),
    .rd_scaled(rd_scaled), .rd_out_of_range(rd_out_of_range), .temp_count(temp_count),
    .ref_count(ref_count), .cal_busy(cal_busy)
  );
  rca_ramp_model rca_ramp_model_inst (
    .clk(clk), .mux_sel(mux_sel), .ramp_start_input(ramp_start_input),
    .ramp_end_input(ramp_end_input), .capture_stop_input(capture_stop_input),
    .thermistor_capture_input(thermistor_capture_input)
  );

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // scaled value: ideal reference over measured one, clipped at full scale
  function automatic logic [11:0] scl(input int raw, input int rc);
    int v;
    v = (rc == 0) ? raw : raw * `RCA_REF_NOMINAL / rc;
    return (v > 4095) ? 12'hfff : 12'(v);
  endfunction

  // read one channel, answer lands one cycle later
  task automatic rd(input logic [2:0] ch, input logic [11:0] res, avg, input logic oor);
    rd_chan = ch;
    @(posedge clk);
    #2 check("rd_result", res, rd_result);
    check("rd_average", avg, rd_average);
    check("rd_out_of_range", {11'h0, oor}, {11'h0, rd_out_of_range});
  endtask

  // one conversion on the expected mux code; irq is due as the ramp ends
  task automatic conv(input int len, input logic [2:0] sel);
    repeat (2) @(posedge clk);
    #2 check("mux_sel", {9'h0, sel}, {9'h0, mux_sel});
    rca_ramp_model_inst.ramp(len);
    check("eor_irq", 12'h001, {11'h0, eor_irq});
    repeat (3) @(posedge clk);
    #2;
  endtask

  task automatic conclude();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("mux_sel", 12'h000, {9'h0, mux_sel});
    check("ref_count", 12'h000, ref_count);
    check("cal_busy", 12'h000, {11'h0, cal_busy});
    for (int c = 0; c < 4; c++) rd(3'(c), 12'h000, 12'h000, 1'b1);
    rd(3'h5, 12'h000, 12'h000, 1'b0);
  endtask

  // a ramp end while idle must not interrupt
  task automatic t_stray();
    int seen;
    seen = 0;
    rca_ramp_model_inst.end_only();
    repeat (4) begin
      if (eor_irq !== 1'b0) seen++;
      @(posedge clk);
      #2;
    end
    check("eor_irq on stray end", 12'h000, 12'(seen));
  endtask

  // spare channels: one stopped after 20 counts, the other left running
  task automatic t_aux();
    aux_start_input = 2'b11;
    @(posedge clk);
    #2 aux_start_input = 2'b00;
    repeat (20) @(posedge clk);
    #2 aux_stop_input = 2'b01;
    repeat (4) @(posedge clk);
    #2 check("aux_count0", 12'd20, aux_count[0]);
    check("aux_valid", 12'h001, {10'h0, aux_valid});
    check("aux_count1", 12'd24, aux_count[1]);
    aux_stop_input = 2'b00;
  endtask

  // calibration spread over three ramps, then scaled and averaged reads
  task automatic t_conv();
    conv(600, 3'h0);
    check("cal_busy open", 12'h001, {11'h0, cal_busy});
    rd(3'h0, 12'd100, 12'd100, 1'b0);
    check("rd_scaled raw", 12'd100, rd_scaled);
    conv(600, 3'h4);
    conv(600, 3'h1);
    check("temp_count", 12'd77, temp_count);
    rd(3'h1, 12'd500, 12'd500, 1'b0);
    conv(600, 3'h2);
    rd(3'h2, 12'h000, 12'h000, 1'b1);
    check("ref_count", 12'd330, ref_count);
    check("cal_busy done", 12'h000, {11'h0, cal_busy});
    conv(600, 3'h3);
    rd(3'h3, 12'd250, 12'd250, 1'b0);
    check("rd_scaled", scl(250, 330), rd_scaled);
    avg_enable = 1'b1;
    rca_ramp_model_inst.trip[0] = 16'd500;
    conv(600, 3'h0);
    avg_enable = 1'b0;
    rd(3'h0, 12'd500, 12'd300, 1'b0);
    check("rd_scaled clip", scl(500, 330), rd_scaled);
  endtask

  // last count below full scale is valid, full scale is not
  task automatic t_limits();
    rca_ramp_model_inst.trip[1] = 16'd4094;
    rca_ramp_model_inst.trip[2] = 16'd4095;
    conv(4100, 3'h1);
    rd(3'h1, 12'd4094, 12'd4094, 1'b0);
    conv(4100, 3'h2);
    rd(3'h2, 12'h000, 12'h000, 1'b1);
  endtask

  // second reference ramp must follow one calibration period after reset
  task automatic t_recal();
    int t;
    t = 0;
    for (int k = 0; k < 10 && t == 0; k++) begin
      repeat (2) @(posedge clk);
      #2 if (mux_sel === 3'h4) t = cyc;
      rca_ramp_model_inst.ramp(600);
      repeat (3) @(posedge clk);
      #2;
    end
    compares++;
    if (t < CAL || t > CAL + 1300) begin
      n_mismatch++;
      $display("[FAIL] recal start expected %0d..%0d seen %0d", CAL, CAL + 1300, t);
    end
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    #2 sys_rst = 1'b0;
    t_reset();
    t_stray();
    t_aux();
    t_conv();
    t_limits();
    t_recal();
    conclude();
  end

  // watchdog, well past the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    $display("[FAIL] watchdog expected done seen hang");
    conclude();
  end
endmodule
